/* logic/uphf_header_formatter.sv */
// header formatter: field packing, check, scrambling, outer code, tails
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module uphf_header_formatter #(
	parameter int MIFS_NS = 1000,
	parameter int GAP_CYCLES = (MIFS_NS + uphf_pkg::CLK_PERIOD_NS - 1) /
		uphf_pkg::CLK_PERIOD_NS,
	parameter logic [3:0][14:0] SEED_VALUES =
		{15'h0008, 15'h0004, 15'h0002, 15'h0001}
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// bit stream to the convolutional encoder
	input wire logic hdr_ready_i,
	output logic hdr_bit_o,
	output logic hdr_valid_o,
	output logic hdr_r13_qpsk_o
);
	import uphf_pkg::*;

	logic rst_meta_r, rst_n_r;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r, cfg_r, rx_hdr_r, rd_val;
	logic band_r, refused_r;
	uphf_state_t state_r, state_nxt;
	logic [6:0] cnt_r, seg_len;
	logic [15:0] gap_cnt_r, crc_r;
	logic [39:0] phy_hdr_r;
	logic [14:0] prbs_r;
	logic [7:0] mac_sh_r, byte_sh_r, frame_cnt_r, rs_in, rs_fb;
	logic [3:0] mac_idx_r;
	logic [7:0] rs_r [0:5];
	logic [47:0] par_sh_r;
	logic bit_r, valid_r, r13_r;
	logic apb_setup, apb_wr, mac_hit, mapped;
	logic start_req, cfg_ok, start_ok;
	logic streaming, step, seg_last;
	logic bit_nxt, raw_bit, prbs_x, rs_feed, valid_nxt;

	uphf_mem_if #(.AW(4)) mac_port ();

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_r);

	// ------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ------------------------------------------------------------------
	// apb slave, one wait state so that read data leave a flip-flop
	// ------------------------------------------------------------------
	assign apb_setup = psel_i & penable_i & ~pready_r;
	assign apb_wr = psel_i & penable_i & pready_r & pwrite_i;
	assign mac_hit = (paddr_i[1:0] == 2'h0) && (paddr_i >= ADDR_MAC_BASE) &&
		(paddr_i <= ADDR_MAC_LAST);
	assign mapped = mac_hit || paddr_i == ADDR_CTRL || paddr_i == ADDR_CFG ||
		paddr_i == ADDR_BAND || paddr_i == ADDR_STAT ||
		paddr_i == ADDR_RXHDR || paddr_i == ADDR_RXFLD;

	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (paddr_i)
			ADDR_CFG: rd_val = cfg_r;
			ADDR_BAND: rd_val = {31'h0000_0000, band_r};
			ADDR_STAT: rd_val = {25'h000_0000,
				rx_hdr_r[TFC_LO+:4] < TFC_FIRST ||
				rx_hdr_r[TFC_LO+:4] > TFC_LAST,
				rx_hdr_r[RATE_LO+:5] > RATE_LAST,
				cfg_r[TFC_LO+:4] < TFC_FIRST || cfg_r[TFC_LO+:4] > TFC_LAST,
				cfg_r[RATE_LO+:5] > RATE_LAST,
				refused_r, state_r == ST_GAP, state_r != ST_IDLE};
			ADDR_RXHDR: rd_val = rx_hdr_r;
			// unassigned bits of a received header are masked here; ADDR_RXHDR still returns them
			ADDR_RXFLD: rd_val = rx_hdr_r & FIELD_MASK;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= apb_setup;
			pslverr_r <= apb_setup & ~mapped;
			if (apb_setup & ~pwrite_i)
				prdata_r <= rd_val;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			cfg_r <= 32'h0000_0000;
			band_r <= 1'b0;
			rx_hdr_r <= 32'h0000_0000;
		end
		else if (apb_wr)
		begin
			if (paddr_i == ADDR_CFG)
				cfg_r <= pwdata_i;
			if (paddr_i == ADDR_BAND)
				band_r <= pwdata_i[0];
			if (paddr_i == ADDR_RXHDR)
				rx_hdr_r <= pwdata_i;
		end
	end

	assign mac_port.wr_en = apb_wr & mac_hit;
	assign mac_port.wr_addr = 4'((paddr_i - ADDR_MAC_BASE) >> 2);
	assign mac_port.wr_data = pwdata_i[7:0];
	assign mac_port.rd_addr = mac_idx_r;

	uphf_mac_mem #(.DEPTH(10)) u_mac_mem (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_r),
		.port(mac_port.mem)
	);

	// ------------------------------------------------------------------
	// start control
	// ------------------------------------------------------------------
	assign start_req = apb_wr && paddr_i == ADDR_CTRL && pwdata_i[CTRL_START];
	assign cfg_ok = cfg_r[RATE_LO+:5] <= RATE_LAST &&
		cfg_r[TFC_LO+:4] >= TFC_FIRST &&
		cfg_r[TFC_LO+:4] <= TFC_LAST;
	assign start_ok = start_req && state_r == ST_IDLE && cfg_ok;

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			refused_r <= 1'b0;
		else if (start_req && !start_ok)
			refused_r <= 1'b1;
		else if (start_ok)
			refused_r <= 1'b0;
	end

	// mac-given fields are copied as they are, unassigned bits forced low
	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			phy_hdr_r <= 40'h00_0000_0000;
		else if (start_ok)
			phy_hdr_r <= {7'h00, band_r,
				cfg_r & FIELD_MASK};
	end

	// ------------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------------
	assign streaming = state_r != ST_IDLE && state_r != ST_GAP;
	assign step = streaming & (~valid_r | hdr_ready_i);
	assign seg_last = step && cnt_r == seg_len - 7'h01;

	always_comb
	begin
		state_nxt = state_r;
		seg_len = HDR_BITS;
		case (state_r)
			ST_IDLE: if (start_ok) state_nxt = ST_PHY;
			ST_PHY: begin seg_len = HDR_BITS;
				if (seg_last) state_nxt = ST_TAIL1; end
			ST_TAIL1: begin seg_len = TAIL1_BITS;
				if (seg_last) state_nxt = ST_MAC; end
			ST_MAC: begin seg_len = MAC_BITS;
				if (seg_last) state_nxt = ST_HCS; end
			ST_HCS: begin seg_len = HCS_BITS;
				if (seg_last) state_nxt = ST_TAIL2; end
			ST_TAIL2: begin seg_len = TAIL2_BITS;
				if (seg_last) state_nxt = ST_PAR; end
			ST_PAR: begin seg_len = PAR_BITS;
				if (seg_last) state_nxt = ST_TAIL3; end
			ST_TAIL3: begin seg_len = TAIL3_BITS;
				// a zero flag means the next packet belongs to the burst
				if (seg_last) state_nxt = phy_hdr_r[BM_POS] ?
					ST_IDLE : ST_GAP; end
			ST_GAP: if (gap_cnt_r == 16'h0000) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 7'h00;
		end
		else
		begin
			state_r <= state_nxt;
			if (start_ok || seg_last)
				cnt_r <= 7'h00;
			else if (step)
				cnt_r <= cnt_r + 7'h01;
		end
	end

	// starts are refused until the gap has run out
	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			gap_cnt_r <= 16'h0000;
		else if (state_r == ST_TAIL3 && state_nxt == ST_GAP)
			gap_cnt_r <= 16'(GAP_CYCLES - 1);
		else if (state_r == ST_GAP && gap_cnt_r != 16'h0000)
			gap_cnt_r <= gap_cnt_r - 16'h0001;
	end

	// ------------------------------------------------------------------
	// bit selection
	// ------------------------------------------------------------------
	assign prbs_x = prbs_r[13] ^ prbs_r[14];
	assign raw_bit = state_r == ST_PHY ? phy_hdr_r[cnt_r[5:0]] : mac_sh_r[0];

	always_comb
	begin
		case (state_r)
			ST_PHY: bit_nxt = phy_hdr_r[cnt_r[5:0]];
			ST_MAC: bit_nxt = mac_sh_r[0] ^ prbs_x;
			ST_HCS: bit_nxt = ~crc_r[15] ^ prbs_x;
			ST_PAR: bit_nxt = par_sh_r[0];
			default: bit_nxt = 1'b0;
		endcase
	end

	// check register sees the unscrambled bits in sending order
	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			crc_r <= CRC_INIT;
		else if (start_ok)
			crc_r <= CRC_INIT;
		else if (step && (state_r == ST_PHY || state_r == ST_MAC))
			crc_r <= {crc_r[14:0], 1'b0} ^
				((raw_bit ^ crc_r[15]) ? CRC_POLY : 16'h0000);
		else if (step && state_r == ST_HCS)
			crc_r <= {crc_r[14:0], 1'b0};
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			prbs_r <= 15'h0000;
		else if (start_ok)
			prbs_r <= SEED_VALUES[cfg_r[SEED_LO+:2]];
		else if (step && (state_r == ST_MAC || state_r == ST_HCS))
			prbs_r <= {prbs_r[13:0], prbs_x};
	end

	// the store answers one cycle late, so the next octet is always
	// addressed a whole octet ahead of its use
	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			mac_sh_r <= 8'h00;
			mac_idx_r <= 4'h0;
		end
		else if (start_ok)
			mac_idx_r <= 4'h0;
		else if ((state_r == ST_TAIL1 && seg_last) ||
			(step && state_r == ST_MAC && cnt_r[2:0] == OCTET_LAST &&
			!seg_last))
		begin
			mac_sh_r <= mac_port.rd_data;
			if (mac_idx_r != MAC_OCTETS - 4'h1)
				mac_idx_r <= mac_idx_r + 4'h1;
		end
		else if (step && state_r == ST_MAC)
			mac_sh_r <= {1'b0, mac_sh_r[7:1]};
	end

	// ------------------------------------------------------------------
	// outer code: octets gathered LSB first as they are sent
	// ------------------------------------------------------------------
	assign rs_feed = step && cnt_r[2:0] == OCTET_LAST &&
		(state_r == ST_PHY || state_r == ST_MAC || state_r == ST_HCS);
	assign rs_in = {bit_nxt, byte_sh_r[7:1]};
	assign rs_fb = rs_in ^ rs_r[5];

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			byte_sh_r <= 8'h00;
		else if (step)
			byte_sh_r <= rs_in;
	end

	for (genvar i = 0; i < 6; i++)
	begin : g_rs
		always_ff @(posedge ref_clk_i or negedge rst_n_r)
		begin
			if (!rst_n_r)
				rs_r[i] <= 8'h00;
			else if (start_ok)
				rs_r[i] <= 8'h00;
			else if (rs_feed)
				rs_r[i] <= (i == 0 ? 8'h00 : rs_r[i == 0 ? 0 : i-1]) ^
					uphf_gf_mul(rs_fb, RS_GEN[i]);
		end
	end

	// highest parity octet goes first, hence it sits in the low byte
	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			par_sh_r <= 48'h0000_0000_0000;
		else if (step && state_r == ST_TAIL2 && cnt_r == 7'h00)
			par_sh_r <= {rs_r[0], rs_r[1], rs_r[2], rs_r[3], rs_r[4],
				rs_r[5]};
		else if (step && state_r == ST_PAR)
			par_sh_r <= {1'b0, par_sh_r[47:1]};
	end

	// ------------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------------
	assign valid_nxt = step | (valid_r & ~hdr_ready_i);

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			bit_r <= 1'b0;
			valid_r <= 1'b0;
			r13_r <= 1'b0;
			frame_cnt_r <= 8'h00;
		end
		else
		begin
			valid_r <= valid_nxt;
			// coding mode is fixed for the header whatever the rate code
			r13_r <= (state_nxt != ST_IDLE && state_nxt != ST_GAP) |
				valid_nxt;
			if (step)
				bit_r <= bit_nxt;
			if (start_ok)
				frame_cnt_r <= 8'h00;
			else if (step)
				frame_cnt_r <= frame_cnt_r + 8'h01;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign hdr_bit_o = bit_r;
	assign hdr_valid_o = valid_r;
	assign hdr_r13_qpsk_o = r13_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence seq_phy_done;
		state_r == ST_PHY && step && cnt_r == 7'h27;
	endsequence
	sequence seq_frame_end;
		state_r == ST_TAIL3 && step && cnt_r == 7'h03;
	endsequence
	chk_phy_to_tail: assert property (
		seq_phy_done |=> state_r == ST_TAIL1)
		else $error("header length wrong");
	chk_frame_len: assert property (
		seq_frame_end |=> frame_cnt_r == FRAME_BITS)
		else $error("frame bit count wrong");
	chk_tail_zero: assert property (
		step && (state_r == ST_TAIL1 || state_r == ST_TAIL2 ||
		state_r == ST_TAIL3) |=> !hdr_bit_o)
		else $error("tail bit not zero");
	chk_rate_field: assert property (
		start_ok |=> phy_hdr_r[7:3] == $past(cfg_r[7:3]))
		else $error("rate field misplaced");
	chk_len_field: assert property (
		start_ok |=> phy_hdr_r[19:8] == $past(cfg_r[19:8]))
		else $error("length field misplaced");
	chk_tfc_field: assert property (
		start_ok |=> phy_hdr_r[31:28] == $past(cfg_r[31:28]))
		else $error("code field misplaced");
	chk_resv_zero: assert property (
		state_r != ST_IDLE |-> (phy_hdr_r[31:0] & ~FIELD_MASK) == 32'h0 &&
		phy_hdr_r[39:33] == 7'h0)
		else $error("unassigned header bit set");
	chk_crc_start: assert property (
		start_ok |=> crc_r == CRC_INIT ##1 state_r == ST_PHY)
		else $error("check register not preset");
	chk_rate_refuse: assert property (
		start_req && state_r == ST_IDLE && cfg_r[7:3] > RATE_LAST |=>
		state_r == ST_IDLE && refused_r)
		else $error("reserved rate accepted");
	chk_gap_hold: assert property (
		state_r == ST_GAP && gap_cnt_r != 16'h0 |=>
		state_r == ST_GAP && $stable(phy_hdr_r))
		else $error("gap cut short");
	chk_r13_flag: assert property (
		step |=> hdr_r13_qpsk_o && hdr_valid_o)
		else $error("coding flag low in header");
endmodule
`default_nettype wire

/* logic/uphf_pkg.sv */
// constants, types and helpers shared by the header formatter
`default_nettype none
package uphf_pkg;
	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	// ------------------------------------------------------------------
	// frame segments, in bits; MAC header length in octets
	// ------------------------------------------------------------------
	localparam logic [6:0] HDR_BITS = 7'h28;
	localparam logic [6:0] TAIL1_BITS = 7'h06;
	localparam logic [6:0] MAC_BITS = 7'h50;
	localparam logic [6:0] HCS_BITS = 7'h10;
	localparam logic [6:0] TAIL2_BITS = 7'h06;
	localparam logic [6:0] PAR_BITS = 7'h30;
	localparam logic [6:0] TAIL3_BITS = 7'h04;
	localparam logic [7:0] FRAME_BITS = 8'hC8;
	localparam logic [2:0] OCTET_LAST = 3'h7;
	localparam logic [3:0] MAC_OCTETS = 4'hA;
	// ------------------------------------------------------------------
	// header field layout
	// ------------------------------------------------------------------
	localparam int RATE_LO = 3;
	localparam int LEN_LO = 8;
	localparam int SEED_LO = 22;
	localparam int BM_POS = 26;
	localparam int PT_POS = 27;
	localparam int TFC_LO = 28;
	localparam int BG_POS = 32;
	localparam logic [31:0] FIELD_MASK = 32'hFCCFFFF8;
	localparam logic [4:0] RATE_LAST = 5'h07;
	localparam logic [3:0] TFC_FIRST = 4'h1;
	localparam logic [3:0] TFC_LAST = 4'hA;
	// ------------------------------------------------------------------
	// check sequence and outer code
	// ------------------------------------------------------------------
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [7:0] GF_POLY = 8'h1D;
	localparam logic [5:0][7:0] RS_GEN =
		{8'h7E, 8'h04, 8'h9E, 8'h3A, 8'h31, 8'h75};
	// ------------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CFG = 12'h004;
	localparam logic [11:0] ADDR_BAND = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam logic [11:0] ADDR_RXHDR = 12'h010;
	localparam logic [11:0] ADDR_RXFLD = 12'h014;
	localparam logic [11:0] ADDR_MAC_BASE = 12'h020;
	localparam logic [11:0] ADDR_MAC_LAST = 12'h044;
	localparam int CTRL_START = 0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_PHY = 4'h1, ST_TAIL1 = 4'h2, ST_MAC = 4'h3,
		ST_HCS = 4'h4, ST_TAIL2 = 4'h5, ST_PAR = 4'h6, ST_TAIL3 = 4'h7,
		ST_GAP = 4'h8
	} uphf_state_t;
	function automatic logic [7:0] uphf_gf_mul(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] acc;
		logic [7:0] x;
		acc = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				acc = acc ^ x;
			x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
		end
		return acc;
	endfunction
endpackage
`default_nettype wire

/* logic/uphf_mem_if.sv */
// carrier between the formatter and its MAC header store
`timescale 1ns/100ps
`default_nettype none
interface uphf_mem_if #(parameter int AW = 4);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [7:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* logic/uphf_mac_mem.sv */
// octet store for the MAC header, registered read
`timescale 1ns/100ps
`default_nettype none
module uphf_mac_mem #(
	parameter int DEPTH = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// access
	uphf_mem_if.mem port
);
	logic [7:0] store [0:DEPTH-1];
	always_ff @(posedge clk_i)
	begin
		if (port.wr_en)
			store[port.wr_addr] <= port.wr_data;
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			port.rd_data <= 8'h00;
		else
			port.rd_data <= store[port.rd_addr];
	end
endmodule
`default_nettype wire

/* tb/uphf_sink_model.sv */
// encoder-side bit sink that captures the header stream
`timescale 1ns/100ps
`default_nettype none
module uphf_sink_model (
	// clock and control
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic slow_i,
	// stream
	input wire logic bit_i,
	input wire logic valid_i,
	input wire logic r13_i,
	output logic ready_o,
	// capture
	output logic [199:0] bits_o,
	output var int count_o,
	output var int r13_miss_o
);
	int ph;
	initial
	begin
		ph = 0;
		ready_o = 1'b0;
		bits_o = '0;
		count_o = 0;
		r13_miss_o = 0;
	end
	// a slow encoder takes one bit in three, so valid must hold
	always @(posedge clk_i)
	begin
		ph <= (ph + 1) % 3;
		ready_o <= !slow_i || (ph == 0);
		if (clr_i)
		begin
			count_o <= 0;
			r13_miss_o <= 0;
		end
		else if (valid_i && ready_o && count_o < 200)
		begin
			bits_o[count_o] <= bit_i;
			count_o <= count_o + 1;
			if (r13_i !== 1'b1)
				r13_miss_o <= r13_miss_o + 1;
		end
	end
endmodule
`default_nettype wire

/* tb/uphf_header_formatter_tb.sv */
// self-checking bench: apb tasks, frame model, refusals
`timescale 1ns/100ps
`default_nettype none
module uphf_header_formatter_tb;
	import uphf_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic clr = 1'b0;
	logic slow = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, rdy, hbit, hval, r13;
	logic [199:0] got;
	int cnt, miss;
	int cyc = 0;
	int n_mismatch = 0;
	int check_count = 0;
	logic [31:0] rd;
	logic er;
	logic [79:0] macv;
	logic [31:0] bad [4] = '{32'h10000040, 32'h00000000, 32'hB0000000,
		32'hF00000F8};
	// gap long enough that a start right after a burst frame falls in it
	uphf_header_formatter #(.GAP_CYCLES(40)) uphf_header_formatter_inst (
		.ref_clk_i(clk), .resetn_i(resetn), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .hdr_ready_i(rdy), .hdr_bit_o(hbit),
		.hdr_valid_o(hval), .hdr_r13_qpsk_o(r13));
	uphf_sink_model uphf_sink_model_inst (.clk_i(clk), .clr_i(clr),
		.slow_i(slow), .bit_i(hbit), .valid_i(hval), .r13_i(r13),
		.ready_o(rdy), .bits_o(got), .count_o(cnt), .r13_miss_o(miss));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	// --------------------
	// helpers
	// --------------------
	task automatic chk(input logic [199:0] g, input logic [199:0] e);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// the request stands until the edge that samples pready high
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [7:0] gm(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] y;
		y = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				y = y ^ a;
			a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
		end
		return y;
	endfunction
	function automatic logic [199:0] frame(input logic [31:0] cfg,
		input logic bg);
		logic [39:0] h;
		logic [95:0] s;
		logic [15:0] c;
		logic [14:0] p;
		logic [5:0][7:0] r;
		logic [5:0][7:0] g;
		logic [47:0] pr;
		logic [135:0] m;
		logic [7:0] fb;
		logic x;
		g = {8'h7E, 8'h04, 8'h9E, 8'h3A, 8'h31, 8'h75};
		h = {7'h00, bg, cfg & 32'hFCCFFFF8};
		s = {16'h0000, macv};
		c = 16'hFFFF;
		for (int i = 0; i < 120; i++)
		begin
			x = c[15] ^ (i < 40 ? h[i] : s[i - 40]);
			c = {c[14:0], 1'b0} ^ (x ? 16'h1021 : 16'h0000);
		end
		for (int i = 0; i < 16; i++)
			s[80 + i] = ~c[15 - i];
		p = 15'h0001 << cfg[23:22];
		for (int i = 0; i < 96; i++)
		begin
			x = p[13] ^ p[14];
			p = {p[13:0], x};
			s[i] = s[i] ^ x;
		end
		m = {s, h};
		r = '0;
		for (int k = 0; k < 17; k++)
		begin
			fb = m[8 * k +: 8] ^ r[5];
			for (int j = 5; j > 0; j--)
				r[j] = r[j - 1] ^ gm(fb, g[j]);
			r[0] = gm(fb, g[0]);
		end
		for (int q = 0; q < 6; q++)
			pr[8 * q +: 8] = r[5 - q];
		return {4'h0, pr, 6'h00, s, 6'h00, h};
	endfunction
	task automatic send(input logic [31:0] cfg, input logic bg,
		input logic sl);
		@(posedge clk);
		clr <= 1'b1;
		slow <= sl;
		@(posedge clk);
		clr <= 1'b0;
		apb(1'b1, ADDR_CFG, cfg);
		apb(1'b1, ADDR_BAND, {31'h0, bg});
		apb(1'b1, ADDR_CTRL, 32'h1);
		for (int i = 0; i < 2000 && cnt < 200; i++)
			@(posedge clk);
		repeat (5) @(posedge clk);
		chk(cnt, 200);
		chk(got, frame(cfg, bg));
		chk(miss, 0);
	endtask
	task automatic conclude();
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// --------------------
	// tests
	// --------------------
	initial
	begin
		repeat (10) @(posedge clk);
		chk({pready, hval, r13}, 3'b000);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, 12'h018, 32'h0);
		chk({er, rd}, 33'h100000000);
		apb(1'b1, ADDR_RXHDR, 32'hFFFFFFFF);
		apb(1'b0, ADDR_RXFLD, 32'h0);
		chk(rd, 32'hFCCFFFF8);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd[6:5], 2'b11);
		for (int i = 0; i < 10; i++)
		begin
			macv[8 * i +: 8] = {i[3:0], ~i[3:0]};
			apb(1'b1, ADDR_MAC_BASE + 12'(4 * i), {24'h0, ~i[3:0], i[3:0]});
			macv[8 * i +: 8] = {~i[3:0], i[3:0]};
		end
		apb(1'b0, ADDR_MAC_BASE, 32'h0);
		chk(rd, 32'h0);
		send(32'hA73ABC3F, 1'b1, 1'b0);
		send(32'h18400128, 1'b0, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd[2], 1'b1);
		chk(rd[1], 1'b1);
		foreach (bad[i])
		begin
			apb(1'b1, ADDR_CFG, bad[i]);
			apb(1'b1, ADDR_CTRL, 32'h1);
			repeat (10) @(posedge clk);
			apb(1'b0, ADDR_STAT, 32'h0);
			chk(rd[4:2], {bad[i][31:28] < 4'h1 || bad[i][31:28] > 4'hA,
				bad[i][7:3] > 5'h07, 1'b1});
			chk(hval, 1'b0);
		end
		send(32'h54800000, 1'b0, 1'b0);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd[2:0], 3'b000);
		conclude();
	end
endmodule
`default_nettype wire
